// >>> logic/emm_pkg.sv
package emm_pkg;

    // Host I/O port addresses
    localparam logic [7:0] PORT_PAGE_INDEX  = 8'hE8;  // Page register select and mode
    localparam logic [7:0] PORT_DATA_LOW    = 8'hEA;  // Translation bits A14-A21
    localparam logic [7:0] PORT_DATA_HIGH   = 8'hEB;  // Translation bits A22-A25
    localparam logic [7:0] PORT_CFG_INDEX   = 8'hEC;  // Indexed configuration select
    localparam logic [7:0] PORT_CFG_DATA    = 8'hED;  // Indexed configuration data
    localparam logic [7:0] PORT_GATE_FIRST  = 8'hE8;  // Lowest protected port
    localparam logic [7:0] PORT_GATE_LAST   = 8'hEF;  // Highest protected port
    localparam logic [7:0] PORT_ACCESS_SHUT = 8'hF9;  // Dummy write closes the gate
    localparam logic [7:0] PORT_ACCESS_OPEN = 8'hFB;  // Dummy write opens the gate

    // Indexed configuration register numbers
    localparam logic [7:0] CFG_SHADOW_SEG_A = 8'h20;  // First of six segment controls
    localparam logic [7:0] CFG_MISC         = 8'h14;  // Miscellaneous settings

    // Page select index fields
    localparam int IDX_BANK_BIT = 7;                  // 0 standard, 1 alternate
    localparam int IDX_AUTO_BIT = 6;                  // Advance after high-byte access
    localparam int IDX_NUM_W    = 6;                  // Register number width

    // Miscellaneous settings fields
    localparam int MISC_MIDDLE_BIOS_BIT = 5;          // Middle BIOS to board DRAM

    // Reset values
    localparam logic [7:0] INDEX_RESET  = 8'h00;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET   = 8'h00;

    // Read-back fill values
    localparam logic [3:0] RESERVED_ONES = 4'hF;      // Upper nibble of each page register
    localparam logic [7:0] IDLE_BYTE     = 8'hFF;     // Unmapped or gated read

    // Page translation field
    localparam int PAGE_FIELD_W = 12;                 // A14-A25
    localparam int PAGE_LOW_W   = 8;                  // A14-A21
    localparam int PAGE_OFS_W   = 14;                 // 16K window offset

    // Memory map, counted in 16K windows (address bits 25..14)
    localparam logic [11:0] WIN_PAGE_FIRST = 12'h030;  // C0000h
    localparam logic [11:0] WIN_PAGE_LAST  = 12'h03B;  // EC000h
    localparam logic [11:0] WIN_FILL_FIRST = 12'h010;  // 40000h
    localparam logic [11:0] WIN_FILL_LAST  = 12'h027;  // 9C000h
    localparam logic [5:0]  PAGE_WIN_COUNT = 6'h0C;    // Twelve page windows
    localparam logic [5:0]  UPPER_MB_TAG   = 6'h00;    // Address bits 25..20 of first MB
    localparam logic [3:0]  SEG_FIRST      = 4'hA;     // A000 segment
    localparam logic [3:0]  SEG_ROM_FIRST  = 4'hE;     // E000 and F000 hold ROM
    localparam logic [8:0]  MIDDLE_BIOS_TAG = 9'h07F;  // 00FE0000h, bits 25..17

    // Two-bit paragraph access modes
    typedef enum logic [1:0] {
        SHADOW_NORMAL     = 2'b00,
        SHADOW_SETUP      = 2'b01,
        SHADOW_READ_ONLY  = 2'b10,
        SHADOW_READ_WRITE = 2'b11
    } shadow_mode_t;

    // Host I/O cycle, one-cycle strobes
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        word;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } io_req_t;

    // CPU memory cycle to steer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [25:0] addr;
    } mem_req_t;

    // Memory steering result
    typedef struct packed {
        logic dram;
        logic slot;
        logic rom_chip_select_n;
    } route_t;

    // Page translation result
    typedef struct packed {
        logic        hit;
        logic [25:0] addr;
    } trans_t;

endpackage

// >>> logic/expanded_memory_map.sv
`timescale 1ns/10ps

// Notes on behaviour
// - Six low index bits select register 0-35
// - Index bit 6 enables automatic number advance
// - Index bit 7 selects standard or alternate bank
// - Low data byte holds A14-A21
// - High data byte low nibble holds A22-A25
// - Word access at low port moves A14-A25
// - Without advance, same register stays selected
// - High byte access advances number, index shows it
// - Word access counts as low then high
// - Top four register bits read as ones
// - Any write to F9-neighbour open port opens gate
// - Any write to close port shuts gate
// - Gate covers ports E8h through EFh
// - Six segment registers, two bits per 16K
// - Normal mode: slot bus or ROM select
// - Read/write mode: board DRAM both ways
// - Read-only mode: read DRAM, write slot
// - Setup: write DRAM, read ROM or slot
// - Misc bit 5 sends middle BIOS to DRAM
// - Registers 0-11 page windows, rest backfill
module expanded_memory_map #(
    parameter int NUM_PAGE_REGS = 36                    // Registers per bank
) (
    input  wire logic              CLK,
    input  wire logic              RSTN,
    input  wire emm_pkg::io_req_t  IO_REQ,
    output logic [15:0]            IO_RDATA,
    output logic                   IO_RVALID,
    output logic                   GATE_OPEN,
    input  wire emm_pkg::mem_req_t MEM_REQ,
    input  wire logic              ALT_SET_ACTIVE,
    output emm_pkg::route_t        MEM_ROUTE,
    output emm_pkg::trans_t        TRANS
);
    import emm_pkg::*;

    // Refuse a bank size the six-bit number or the backfill map cannot serve
    if (NUM_PAGE_REGS < 12 || NUM_PAGE_REGS > 36) begin : g_bad_size
        $error("NUM_PAGE_REGS must lie between 12 and 36");
    end

    localparam logic [5:0] LAST_REG = 6'(NUM_PAGE_REGS - 1);  // Highest valid number

    // Register number is one the bank really holds
    function automatic logic num_valid(input logic [5:0] num);
        num_valid = (num <= LAST_REG);
    endfunction

    // Port lies in the gated range
    function automatic logic port_gated(input logic [7:0] addr);
        port_gated = (addr >= PORT_GATE_FIRST) && (addr <= PORT_GATE_LAST);
    endfunction

    // Page register number that translates a 16K window, with hit flag
    function automatic logic [6:0] window_lookup(input logic [25:0] addr);
        logic [11:0] win;
        win = addr[25:14];
        window_lookup = 7'h00;
        if (win >= WIN_PAGE_FIRST && win <= WIN_PAGE_LAST) begin
            window_lookup = {1'b1, 6'(win - WIN_PAGE_FIRST)};
        end else if (win >= WIN_FILL_FIRST && win <= WIN_FILL_LAST) begin
            window_lookup = {1'b1, 6'(win - WIN_FILL_FIRST + 12'(PAGE_WIN_COUNT))};
        end
    endfunction

    // Access gate and index state
    logic        gate_open;                             // Protected ports usable
    logic        next_gate_open;
    logic [7:0]  page_index;                            // Bank, advance, number
    logic [7:0]  next_page_index;
    logic [7:0]  cfg_index;                             // Indexed configuration select
    logic [7:0]  next_cfg_index;
    logic [5:0][7:0] shadow_mode_seg;                   // Segments A through F
    logic [5:0][7:0] next_shadow_mode_seg;
    logic [7:0]  misc_settings;                         // Miscellaneous settings
    logic [7:0]  next_misc_settings;

    // Page translation storage, two banks
    logic [PAGE_FIELD_W-1:0] page_mem [2][NUM_PAGE_REGS];

    // Page storage write controls
    logic                    pg_we_lo;                  // Write A14-A21
    logic                    pg_we_hi;                  // Write A22-A25
    logic                    pg_bank;                   // Target bank
    logic [5:0]              pg_num;                    // Target register
    logic [PAGE_FIELD_W-1:0] pg_wdata;                  // New field value

    // Read answer
    logic [15:0] next_io_rdata;
    logic        next_io_rvalid;

    // Memory steering results
    route_t      next_mem_route;
    trans_t      next_trans;

    // Decoded I/O cycle
    logic        acc_ok;                                // Gated port and gate open
    logic        hit_low;                               // Byte or word at low data port
    logic        hit_high;                              // High data port or word
    logic        hit_word;                              // Word at low data port
    logic [5:0]  sel_num;                               // Selected register
    logic        sel_bank;                              // Selected bank
    logic [PAGE_FIELD_W-1:0] sel_field;                 // Selected field contents
    logic [2:0]  cfg_seg;                               // Segment picked by config index

    // Decode of the host cycle
    always_comb begin
        sel_num  = page_index[IDX_NUM_W-1:0];
        sel_bank = page_index[IDX_BANK_BIT];
        acc_ok   = port_gated(IO_REQ.addr) && gate_open;
        hit_word = IO_REQ.word && (IO_REQ.addr == PORT_DATA_LOW);
        hit_low  = (IO_REQ.addr == PORT_DATA_LOW);
        hit_high = (IO_REQ.addr == PORT_DATA_HIGH) || hit_word;
        cfg_seg  = 3'(cfg_index - CFG_SHADOW_SEG_A);
        if (num_valid(sel_num)) begin
            sel_field = page_mem[sel_bank][sel_num];
        end else begin
            sel_field = {PAGE_FIELD_W{1'b1}};
        end
    end

    // Gate, index and configuration next values
    always_comb begin
        next_gate_open       = gate_open;
        next_page_index      = page_index;
        next_cfg_index       = cfg_index;
        next_shadow_mode_seg = shadow_mode_seg;
        next_misc_settings   = misc_settings;
        // Dummy writes steer the gate, data ignored
        if (IO_REQ.wr && IO_REQ.addr == PORT_ACCESS_OPEN) begin
            next_gate_open = 1'b1;
        end
        if (IO_REQ.wr && IO_REQ.addr == PORT_ACCESS_SHUT) begin
            next_gate_open = 1'b0;
        end
        // Protected writes only while the gate is open
        if (IO_REQ.wr && acc_ok) begin
            if (IO_REQ.addr == PORT_PAGE_INDEX) begin
                next_page_index = IO_REQ.wdata[7:0];
            end
            if (IO_REQ.addr == PORT_CFG_INDEX) begin
                next_cfg_index = IO_REQ.wdata[7:0];
            end
            if (IO_REQ.addr == PORT_CFG_DATA) begin
                if (cfg_index == CFG_MISC) begin
                    next_misc_settings = IO_REQ.wdata[7:0];
                end else if (cfg_index >= CFG_SHADOW_SEG_A &&
                             cfg_index <= CFG_SHADOW_SEG_A + 8'h05) begin
                    next_shadow_mode_seg[cfg_seg] = IO_REQ.wdata[7:0];
                end
            end
        end
        // High-byte or word access advances the number, wrapping at the top
        if ((IO_REQ.rd || IO_REQ.wr) && acc_ok && hit_high &&
            page_index[IDX_AUTO_BIT]) begin
            if (sel_num >= LAST_REG) begin
                next_page_index[IDX_NUM_W-1:0] = 6'h00;
            end else begin
                next_page_index[IDX_NUM_W-1:0] = sel_num + 6'h01;
            end
        end
    end

    // Page storage write controls
    always_comb begin
        pg_bank  = sel_bank;
        pg_num   = sel_num;
        pg_we_lo = 1'b0;
        pg_we_hi = 1'b0;
        pg_wdata = {IO_REQ.wdata[11:8], IO_REQ.wdata[7:0]};
        if (IO_REQ.wr && acc_ok && num_valid(sel_num)) begin
            if (hit_word) begin
                pg_we_lo = 1'b1;
                pg_we_hi = 1'b1;
            end else if (hit_low) begin
                pg_we_lo = 1'b1;
            end else if (hit_high) begin
                pg_we_hi = 1'b1;
                pg_wdata = {IO_REQ.wdata[3:0], IO_REQ.wdata[7:0]};
            end
        end
    end

    // Read data next values
    always_comb begin
        next_io_rvalid = IO_REQ.rd;
        next_io_rdata  = {IDLE_BYTE, IDLE_BYTE};
        if (IO_REQ.rd && acc_ok) begin
            unique case (IO_REQ.addr)
                PORT_PAGE_INDEX: begin
                    next_io_rdata = {IDLE_BYTE, page_index};
                end
                PORT_DATA_LOW: begin
                    if (hit_word) begin
                        next_io_rdata = {RESERVED_ONES, sel_field};
                    end else begin
                        next_io_rdata = {IDLE_BYTE, sel_field[7:0]};
                    end
                end
                PORT_DATA_HIGH: begin
                    next_io_rdata = {IDLE_BYTE, RESERVED_ONES,
                                     sel_field[PAGE_FIELD_W-1:PAGE_LOW_W]};
                end
                PORT_CFG_INDEX: begin
                    next_io_rdata = {IDLE_BYTE, cfg_index};
                end
                PORT_CFG_DATA: begin
                    if (cfg_index == CFG_MISC) begin
                        next_io_rdata = {IDLE_BYTE, misc_settings};
                    end else if (cfg_index >= CFG_SHADOW_SEG_A &&
                                 cfg_index <= CFG_SHADOW_SEG_A + 8'h05) begin
                        next_io_rdata = {IDLE_BYTE, shadow_mode_seg[cfg_seg]};
                    end
                end
                default: begin
                    next_io_rdata = {IDLE_BYTE, IDLE_BYTE};
                end
            endcase
        end
    end

    // Memory steering and page translation next values
    always_comb begin
        logic [6:0]   lookup;
        logic [2:0]   seg;
        logic [1:0]   para;
        shadow_mode_t mode;
        logic         rom_seg;
        lookup = window_lookup(MEM_REQ.addr);
        seg    = 3'(MEM_REQ.addr[19:16] - SEG_FIRST);
        para   = MEM_REQ.addr[15:14];
        mode   = shadow_mode_t'(shadow_mode_seg[seg][2*para +: 2]);
        rom_seg = (MEM_REQ.addr[19:16] >= SEG_ROM_FIRST);
        next_mem_route = '{dram: 1'b0, slot: 1'b0, rom_chip_select_n: 1'b1};
        next_trans     = '{hit: 1'b0, addr: 26'h0000000};
        if (MEM_REQ.valid) begin
            // Translated address uses the active bank
            if (lookup[6] && num_valid(lookup[5:0])) begin
                next_trans.hit  = 1'b1;
                next_trans.addr = {page_mem[ALT_SET_ACTIVE][lookup[5:0]],
                                   MEM_REQ.addr[PAGE_OFS_W-1:0]};
            end
            if (MEM_REQ.addr[25:20] == UPPER_MB_TAG &&
                MEM_REQ.addr[19:16] >= SEG_FIRST) begin
                unique case (mode)
                    SHADOW_NORMAL: begin
                        next_mem_route.slot              = !rom_seg;
                        next_mem_route.rom_chip_select_n = !rom_seg;
                    end
                    SHADOW_READ_WRITE: begin
                        next_mem_route.dram = 1'b1;
                    end
                    SHADOW_READ_ONLY: begin
                        next_mem_route.dram = !MEM_REQ.write;
                        next_mem_route.slot = MEM_REQ.write;
                    end
                    SHADOW_SETUP: begin
                        next_mem_route.dram              = MEM_REQ.write;
                        next_mem_route.slot              = !MEM_REQ.write && !rom_seg;
                        next_mem_route.rom_chip_select_n = MEM_REQ.write || !rom_seg;
                    end
                endcase
            end else if (MEM_REQ.addr[25:17] == MIDDLE_BIOS_TAG) begin
                // Never shadowed; one bit picks ROM or DRAM
                if (misc_settings[MISC_MIDDLE_BIOS_BIT]) begin
                    next_mem_route.dram = 1'b1;
                end else begin
                    next_mem_route.rom_chip_select_n = 1'b0;
                end
            end
        end
    end

    // Control and output registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gate_open       <= 1'b0;
            page_index      <= INDEX_RESET;
            cfg_index       <= CFG_RESET;
            shadow_mode_seg <= {6{SHADOW_RESET}};
            misc_settings   <= MISC_RESET;
            IO_RDATA        <= {IDLE_BYTE, IDLE_BYTE};
            IO_RVALID       <= 1'b0;
            GATE_OPEN       <= 1'b0;
            MEM_ROUTE       <= '{dram: 1'b0, slot: 1'b0, rom_chip_select_n: 1'b1};
            TRANS           <= '{hit: 1'b0, addr: 26'h0000000};
        end else begin
            gate_open       <= next_gate_open;
            page_index      <= next_page_index;
            cfg_index       <= next_cfg_index;
            shadow_mode_seg <= next_shadow_mode_seg;
            misc_settings   <= next_misc_settings;
            IO_RDATA        <= next_io_rdata;
            IO_RVALID       <= next_io_rvalid;
            GATE_OPEN       <= next_gate_open;
            MEM_ROUTE       <= next_mem_route;
            TRANS           <= next_trans;
        end
    end

    // Page storage; contents are undefined until software loads them
    always_ff @(posedge CLK) begin
        if (pg_we_lo) begin
            page_mem[pg_bank][pg_num][PAGE_LOW_W-1:0] <= pg_wdata[PAGE_LOW_W-1:0];
        end
        if (pg_we_hi) begin
            page_mem[pg_bank][pg_num][PAGE_FIELD_W-1:PAGE_LOW_W] <=
                pg_wdata[PAGE_FIELD_W-1:PAGE_LOW_W];
        end
    end

endmodule

// >>> tb/expanded_memory_map_sva.sv
`timescale 1ns/10ps
// Port-level checker for the page register and gate logic
module expanded_memory_map_sva #(
    parameter int NUM_PAGE_REGS = 36                  // Registers per bank
) (
    input wire logic              CLK,
    input wire logic              RSTN,
    input wire emm_pkg::io_req_t  IO_REQ,
    input wire logic [15:0]       IO_RDATA,
    input wire logic              IO_RVALID,
    input wire logic              GATE_OPEN,
    input wire emm_pkg::mem_req_t MEM_REQ,
    input wire emm_pkg::route_t   MEM_ROUTE
);
    import emm_pkg::*;
    // One clock domain, all checks off during reset
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Dummy writes to the two gate ports
    sequence seq_open;
        IO_REQ.wr && IO_REQ.addr == PORT_ACCESS_OPEN;
    endsequence
    sequence seq_shut;
        IO_REQ.wr && IO_REQ.addr == PORT_ACCESS_SHUT;
    endsequence
    // Protected read while the gate is shut
    sequence seq_gated_rd;
        IO_REQ.rd && !GATE_OPEN && IO_REQ.addr >= PORT_GATE_FIRST && IO_REQ.addr <= PORT_GATE_LAST;
    endsequence
    chk_gate_opens: assert property (seq_open |=> GATE_OPEN)
        else $error("gate did not open");
    chk_gate_shuts: assert property (seq_shut |=> !GATE_OPEN)
        else $error("gate did not close");
    chk_gate_holds: assert property (!(IO_REQ.wr && (IO_REQ.addr == PORT_ACCESS_OPEN
        || IO_REQ.addr == PORT_ACCESS_SHUT)) |=> $stable(GATE_OPEN))
        else $error("gate changed without a gate write");
    chk_read_answer: assert property (IO_REQ.rd |=> IO_RVALID)
        else $error("read not answered");
    chk_idle_answer: assert property (!IO_REQ.rd |=> !IO_RVALID && IO_RDATA == 16'hFFFF)
        else $error("answer without a read");
    chk_gated_read: assert property (seq_gated_rd |=> IO_RVALID && IO_RDATA == 16'hFFFF)
        else $error("protected read leaked while gate shut");
    chk_high_fill: assert property (IO_REQ.rd && GATE_OPEN && IO_REQ.addr == PORT_DATA_HIGH
        |=> IO_RDATA[15:4] == 12'hFFF)
        else $error("high byte reserved bits not ones");
    chk_word_fill: assert property (IO_REQ.rd && GATE_OPEN && IO_REQ.word
        && IO_REQ.addr == PORT_DATA_LOW |=> IO_RDATA[15:12] == RESERVED_ONES)
        else $error("word read reserved bits not ones");
    chk_middle_bios: assert property (MEM_REQ.valid && MEM_REQ.addr[25:17] == MIDDLE_BIOS_TAG
        |=> !MEM_ROUTE.slot && MEM_ROUTE.dram == MEM_ROUTE.rom_chip_select_n)
        else $error("middle bios range misrouted");
endmodule
bind expanded_memory_map expanded_memory_map_sva #(
    .NUM_PAGE_REGS(NUM_PAGE_REGS)
) expanded_memory_map_sva_inst (
    .CLK(CLK), .RSTN(RSTN), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
    .GATE_OPEN(GATE_OPEN), .MEM_REQ(MEM_REQ), .MEM_ROUTE(MEM_ROUTE)
);

// >>> tb/host_cpu.sv
`timescale 1ns/10ps
// Host processor issuing byte and word I/O cycles
module host_cpu (
    input  wire logic        clk,
    output emm_pkg::io_req_t io_req,
    input  wire logic [15:0] io_rdata,
    input  wire logic        io_rvalid
);
    import emm_pkg::*;
    // Bus idle at time zero
    initial begin
        io_req = '0;
    end
    // One cycle; callers set the index first, low byte before high, gate open first
    task automatic io_op(input logic rd, input logic word, input logic [7:0] addr,
                         input logic [15:0] wdata, output logic [15:0] rdata, output logic rvalid);
        @(posedge clk);
        io_req <= '{rd: rd, wr: !rd, word: word, addr: addr, wdata: wdata};
        @(posedge clk);
        // Released lines show inverted values, not the last ones
        io_req <= '{rd: 1'b0, wr: 1'b0, word: !word, addr: ~addr, wdata: ~wdata};
        // Answer registered at this edge stands for one cycle only
        #1;
        rdata  = io_rdata;
        rvalid = io_rvalid;
    endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
    import emm_pkg::*;
    // One port access with the read answer it should give
    typedef struct packed {
        logic        rd;
        logic        word;
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } step_t;
    localparam int NSTEP = 30;                        // Rows in the table
    localparam step_t STEPS [NSTEP] = '{
        '{0, 0, 8'hFB, 16'h0000, 16'h0000},
        '{0, 0, 8'hE8, 16'h0000, 16'h0000},
        '{0, 0, 8'hEA, 16'h0034, 16'h0000},
        '{0, 0, 8'hEB, 16'h000C, 16'h0000},
        '{1, 0, 8'hEA, 16'h0000, 16'hFF34},
        '{1, 0, 8'hEB, 16'h0000, 16'hFFFC},
        '{1, 0, 8'hE8, 16'h0000, 16'hFF00},
        '{0, 0, 8'hE8, 16'h0041, 16'h0000},
        '{0, 1, 8'hEA, 16'h0ABC, 16'h0000},
        '{1, 0, 8'hE8, 16'h0000, 16'hFF42},
        '{0, 0, 8'hE8, 16'h0041, 16'h0000},
        '{1, 1, 8'hEA, 16'h0000, 16'hFABC},
        '{1, 0, 8'hE8, 16'h0000, 16'hFF42},
        '{0, 0, 8'hE8, 16'h0080, 16'h0000},
        '{0, 1, 8'hEA, 16'h0555, 16'h0000},
        '{0, 0, 8'hE8, 16'h0000, 16'h0000},
        '{1, 1, 8'hEA, 16'h0000, 16'hFC34},
        '{0, 0, 8'hE8, 16'h00E3, 16'h0000},
        '{0, 1, 8'hEA, 16'h0777, 16'h0000},
        '{1, 0, 8'hE8, 16'h0000, 16'hFFC0},
        '{0, 0, 8'hEA, 16'h0012, 16'h0000},
        '{1, 0, 8'hE8, 16'h0000, 16'hFFC0},
        '{0, 0, 8'hEB, 16'h0003, 16'h0000},
        '{1, 0, 8'hE8, 16'h0000, 16'hFFC1},
        '{0, 0, 8'hF9, 16'h0000, 16'h0000},
        '{0, 0, 8'hE8, 16'h0005, 16'h0000},
        '{1, 0, 8'hE8, 16'h0000, 16'hFFFF},
        '{0, 0, 8'hFB, 16'h0000, 16'h0000},
        '{1, 0, 8'hE8, 16'h0000, 16'hFFC1},
        '{1, 0, 8'h80, 16'h0000, 16'hFFFF}
    };
    // Expected routes {dram, slot, rom_chip_select_n} per paragraph mode
    localparam logic [2:0] RD_ROUTE [4] = '{3'h0, 3'h0, 3'h5, 3'h5};
    localparam logic [2:0] WR_ROUTE [4] = '{3'h0, 3'h5, 3'h3, 3'h5};
    logic        clk = 1'b0;                          // 40 MHz clock
    logic        rstn = 1'b0;                         // Reset, active low
    io_req_t     io_req;                              // Driven by the host model
    logic [15:0] io_rdata;
    logic        io_rvalid;
    logic        gate_open;
    mem_req_t    mem_req = '0;                        // Memory cycle to steer
    logic        alt_set = 1'b0;                      // Translation bank in use
    route_t      mem_route;
    trans_t      trans;
    int          error_cnt = 0;
    int          compares = 0;
    logic [15:0] rdata;
    logic        rvalid;
    // Clock generator
    always #12.5 clk = ~clk;
    expanded_memory_map #(.NUM_PAGE_REGS(36)) expanded_memory_map_inst (
        .CLK(clk), .RSTN(rstn), .IO_REQ(io_req), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid),
        .GATE_OPEN(gate_open), .MEM_REQ(mem_req), .ALT_SET_ACTIVE(alt_set),
        .MEM_ROUTE(mem_route), .TRANS(trans));
    host_cpu host_cpu_inst (.clk(clk), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Indexed configuration write
    task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
        host_cpu_inst.io_op(1'b0, 1'b0, PORT_CFG_INDEX, {8'h00, idx}, rdata, rvalid);
        host_cpu_inst.io_op(1'b0, 1'b0, PORT_CFG_DATA, {8'h00, val}, rdata, rvalid);
    endtask
    // One memory cycle, answer sampled 1 ns after the edge that takes it
    task automatic mem_op(input logic write, input logic [25:0] addr, input logic alt);
        @(posedge clk);
        mem_req <= '{valid: 1'b1, write: write, addr: addr};
        alt_set <= alt;
        @(posedge clk);
        mem_req <= '{valid: 1'b0, write: !write, addr: ~addr};
        // Route and translation stand for one cycle only
        #1;
    endtask
    // Two-cycle reset, then idle outputs checked
    task automatic reset_dut;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check({31'h0, gate_open}, 32'h0);
        check({29'h0, mem_route}, 32'h1);
        check({16'h0, io_rdata}, 32'h0000FFFF);
    endtask
    // Counts and verdict
    task automatic final_report;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    // Main sequence
    initial begin
        reset_dut();
        for (int i = 0; i < NSTEP; i++) begin
            host_cpu_inst.io_op(STEPS[i].rd, STEPS[i].word, STEPS[i].addr, STEPS[i].wdata,
                                rdata, rvalid);
            if (STEPS[i].rd) begin
                check({16'h0, rdata}, {16'h0, STEPS[i].exp});
                check({31'h0, rvalid}, 32'h1);
            end
        end
        mem_op(1'b0, 26'h00C0123, 1'b0);
        check({5'h00, trans}, {5'h00, 1'b1, 12'hC34, 14'h0123});
        mem_op(1'b0, 26'h00C0123, 1'b1);
        check({5'h00, trans}, {5'h00, 1'b1, 12'h312, 14'h0123});
        host_cpu_inst.io_op(1'b0, 1'b0, PORT_PAGE_INDEX, 16'h000C, rdata, rvalid);
        host_cpu_inst.io_op(1'b0, 1'b1, PORT_DATA_LOW, 16'h0456, rdata, rvalid);
        mem_op(1'b0, 26'h0040123, 1'b0);
        check({5'h00, trans}, {5'h00, 1'b1, 12'h456, 14'h0123});
        for (int m = 0; m < 4; m++) begin
            cfg(8'h24, {2'b11, 4'h0, m[1:0]});
            mem_op(1'b0, 26'h00E0000, 1'b0);
            check({29'h0, mem_route}, {29'h0, RD_ROUTE[m]});
            mem_op(1'b1, 26'h00E0000, 1'b0);
            check({29'h0, mem_route}, {29'h0, WR_ROUTE[m]});
            mem_op(1'b0, 26'h00EC000, 1'b0);
            check({29'h0, mem_route}, 32'h5);
        end
        cfg(8'h20, 8'h01);
        mem_op(1'b0, 26'h00A0000, 1'b0);
        check({29'h0, mem_route}, 32'h3);
        mem_op(1'b1, 26'h00A0000, 1'b0);
        check({29'h0, mem_route}, 32'h5);
        mem_op(1'b0, 26'h0FE0000, 1'b0);
        check({29'h0, mem_route}, 32'h0);
        cfg(CFG_MISC, 8'h20);
        mem_op(1'b0, 26'h0FE0000, 1'b0);
        check({29'h0, mem_route}, 32'h5);
        host_cpu_inst.io_op(1'b0, 1'b0, PORT_ACCESS_SHUT, 16'h0000, rdata, rvalid);
        reset_dut();
        mem_op(1'b0, 26'h0FE0000, 1'b0);
        check({29'h0, mem_route}, 32'h0);
        final_report();
    end
endmodule
